// ==== hdl/led_blink_defines.svh ====
// Register map, field positions, reset values and timing constants for the sink blink timer.
`ifndef LED_BLINK_DEFINES_SVH
`define LED_BLINK_DEFINES_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define REG_SINK_ENABLE_ADDR 8'h10
`define REG_BLINK_TIMING_ADDR 8'h11
`define SINK_ENABLE_RESET 8'h00
`define BLINK_TIMING_RESET 8'h00
`define SINK_ENABLE_MASK 8'h7F
`define READ_ZERO 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SHARED_ON_TIME_MSB 7
`define SHARED_ON_TIME_LSB 6
`define CH5_OFF_TIME_LSB 0
`define OFF_TIME_FIELD_W 2
`define CH5_SINK_ENABLE_BIT 4
`define NUM_BLINK_CHANNELS 3

// ----------------------------------------------------------------
// Field codes and their durations in 0.2 s units
// ----------------------------------------------------------------
`define CODE_0 2'h0
`define CODE_1 2'h1
`define CODE_2 2'h2
`define CODE_3 2'h3
`define ON_UNITS_CODE_0 4'h1
`define ON_UNITS_CODE_1 4'h3
`define ON_UNITS_CODE_2 4'h4
`define ON_UNITS_CODE_3 4'h6
`define OFF_UNITS_DISABLED 4'h0
`define OFF_UNITS_CODE_1 4'h3
`define OFF_UNITS_CODE_2 4'h6
`define OFF_UNITS_CODE_3 4'h9

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BLINK_UNIT_MS 200
`define CLK_PERIOD_NS 40
`define NS_PER_MS 1000000
`define UNIT_CYCLES_DEFAULT ((`BLINK_UNIT_MS * `NS_PER_MS) / `CLK_PERIOD_NS)

`endif

// ==== hdl/led_blink_pkg.sv ====
// Types shared by the sink blink timer and its per-channel sequencer.
`default_nettype none
package led_blink_pkg;

	// Blink settings handed to one channel, in 0.2 s units.
	typedef struct packed {
		logic [3:0] on_units;
		logic [3:0] off_units;
	} blink_cfg_t;

	// Channel phase; Gray along idle, on, off.
	typedef enum logic [1:0] {
		PH_IDLE = 2'h0,
		PH_ON = 2'h1,
		PH_OFF = 2'h3
	} blink_phase_t;

endpackage : led_blink_pkg
`default_nettype wire

// ==== hdl/blink_channel.sv ====
// On/off phase sequencer for one independent current sink.
`timescale 1ns/1ns
`default_nettype none
`include "led_blink_defines.svh"

module blink_channel #(
	parameter int UNIT_CYCLES = `UNIT_CYCLES_DEFAULT,
	parameter int CNT_W = 32
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic enable,
	input wire led_blink_pkg::blink_cfg_t cfg,
	output logic sink_on
);

	led_blink_pkg::blink_phase_t phase, next_phase;
	logic [CNT_W-1:0] cnt, next_cnt;
	logic [CNT_W-1:0] on_len, off_len;
	logic next_sink_on;

	// Phase lengths in cycles; the widest is 1.8 s, far below the counter range.
	assign on_len = CNT_W'(cfg.on_units) * CNT_W'(UNIT_CYCLES);
	assign off_len = CNT_W'(cfg.off_units) * CNT_W'(UNIT_CYCLES);

	// Next phase; lengths are compared with >= so a shortened setting ends the phase at once.
	always_comb begin
		next_phase = phase;
		next_cnt = cnt + CNT_W'(1);
		if (!enable) begin
			next_phase = led_blink_pkg::PH_IDLE;
			next_cnt = '0;
		end else begin
			unique case (phase)
				led_blink_pkg::PH_IDLE: begin
					next_phase = led_blink_pkg::PH_ON;
					next_cnt = '0;
				end
				led_blink_pkg::PH_ON: begin
					if (cfg.off_units == `OFF_UNITS_DISABLED) begin
						next_cnt = '0;
					end else if (cnt >= on_len - CNT_W'(1)) begin
						next_phase = led_blink_pkg::PH_OFF;
						next_cnt = '0;
					end
				end
				led_blink_pkg::PH_OFF: begin
					if (cfg.off_units == `OFF_UNITS_DISABLED || cnt >= off_len - CNT_W'(1)) begin
						next_phase = led_blink_pkg::PH_ON;
						next_cnt = '0;
					end
				end
				default: begin
					next_phase = led_blink_pkg::PH_IDLE;
					next_cnt = '0;
				end
			endcase
		end
		next_sink_on = (next_phase == led_blink_pkg::PH_ON);
	end

	// Phase, counter and sink drive registers.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			phase <= led_blink_pkg::PH_IDLE;
			cnt <= '0;
			sink_on <= 1'b0;
		end else begin
			phase <= next_phase;
			cnt <= next_cnt;
			sink_on <= next_sink_on;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	on_phase_end_a: assert property (@(posedge ref_clk) disable iff (srst)
		(phase == led_blink_pkg::PH_ON && enable && cfg.off_units != `OFF_UNITS_DISABLED
		&& cnt >= on_len - CNT_W'(1)) |=> (phase == led_blink_pkg::PH_OFF && !sink_on && cnt == '0))
		else $error("on phase did not end on time");

	steady_on_a: assert property (@(posedge ref_clk) disable iff (srst)
		(enable && cfg.off_units == `OFF_UNITS_DISABLED) |=> sink_on)
		else $error("sink not steadily on with off time disabled");

	off_phase_end_a: assert property (@(posedge ref_clk) disable iff (srst)
		(phase == led_blink_pkg::PH_OFF && enable && cnt >= off_len - CNT_W'(1)) |=> sink_on)
		else $error("off phase did not end on time");

	disable_restart_a: assert property (@(posedge ref_clk) disable iff (srst)
		(!enable ##1 enable) |=> (sink_on && cnt == '0))
		else $error("re-enable did not restart with on phase");

endmodule : blink_channel
`default_nettype wire

// ==== hdl/led_sink_blink_timer.sv ====
// Blink timer for independent current sinks 5, 6 and 7 with its enable and timing registers.
`timescale 1ns/1ns
`default_nettype none
`include "led_blink_defines.svh"

// What this block does
// - Shared on-time code selects 0.2/0.6/0.8/1.2 s.
// - Blinking sink stays on for on time.
// - Channel 7 off code: disabled/0.6/1.2/1.8 s.
// - Channel 6 off code: disabled/0.6/1.2/1.8 s.
// - Channel 5 off code: disabled/0.6/1.2/1.8 s.
// - Off time disabled keeps enabled sink on.
// - Non-zero off time: on, then off, repeating.
// - Enable bit 1 turns sink on, 0 off.

module led_sink_blink_timer #(
	parameter int UNIT_CYCLES = `UNIT_CYCLES_DEFAULT,
	parameter int CNT_W = 32
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	output logic [2:0] sink_on
);

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [7:0] sink_enable, next_sink_enable;
	logic [7:0] sink_blink_timing_a, next_sink_blink_timing_a;
	logic [7:0] next_reg_rdata;
	logic next_reg_rvalid;

	// Writes land in the addressed register; the reserved enable bit is masked so it always reads zero.
	// Channels 1 to 4 keep their enable bits for readback only; they are driven elsewhere.
	always_comb begin
		next_sink_enable = sink_enable;
		next_sink_blink_timing_a = sink_blink_timing_a;
		if (reg_wr && reg_addr == `REG_SINK_ENABLE_ADDR) begin
			next_sink_enable = reg_wdata & `SINK_ENABLE_MASK;
		end
		if (reg_wr && reg_addr == `REG_BLINK_TIMING_ADDR) begin
			next_sink_blink_timing_a = reg_wdata;
		end
	end

	// Reads answer one cycle later; an unmapped address reads as zero rather than holding old data.
	always_comb begin
		next_reg_rvalid = reg_rd;
		next_reg_rdata = reg_rdata;
		if (reg_rd) begin
			unique case (reg_addr)
				`REG_SINK_ENABLE_ADDR: next_reg_rdata = sink_enable;
				`REG_BLINK_TIMING_ADDR: next_reg_rdata = sink_blink_timing_a;
				default: next_reg_rdata = `READ_ZERO;
			endcase
		end
	end

	// Register state and read port.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sink_enable <= `SINK_ENABLE_RESET;
			sink_blink_timing_a <= `BLINK_TIMING_RESET;
			reg_rdata <= `READ_ZERO;
			reg_rvalid <= 1'b0;
		end else begin
			sink_enable <= next_sink_enable;
			sink_blink_timing_a <= next_sink_blink_timing_a;
			reg_rdata <= next_reg_rdata;
			reg_rvalid <= next_reg_rvalid;
		end
	end

	// ----------------------------------------------------------------
	// Field decode
	// ----------------------------------------------------------------

	// Shared on time in 0.2 s units.
	function automatic logic [3:0] on_units_of(input logic [1:0] code);
		logic [3:0] units;
		units = `ON_UNITS_CODE_0;
		unique case (code)
			`CODE_0: units = `ON_UNITS_CODE_0;
			`CODE_1: units = `ON_UNITS_CODE_1;
			`CODE_2: units = `ON_UNITS_CODE_2;
			`CODE_3: units = `ON_UNITS_CODE_3;
		endcase
		return units;
	endfunction : on_units_of

	// Off time in 0.2 s units; zero means blinking is disabled.
	function automatic logic [3:0] off_units_of(input logic [1:0] code);
		logic [3:0] units;
		units = `OFF_UNITS_DISABLED;
		unique case (code)
			`CODE_0: units = `OFF_UNITS_DISABLED;
			`CODE_1: units = `OFF_UNITS_CODE_1;
			`CODE_2: units = `OFF_UNITS_CODE_2;
			`CODE_3: units = `OFF_UNITS_CODE_3;
		endcase
		return units;
	endfunction : off_units_of

	logic [3:0] shared_on_time_units;
	logic [2:0] channel_enable;
	led_blink_pkg::blink_cfg_t channel_cfg [`NUM_BLINK_CHANNELS];

	// One on time serves every blinking channel.
	assign shared_on_time_units = on_units_of(sink_blink_timing_a[`SHARED_ON_TIME_MSB:`SHARED_ON_TIME_LSB]);

	// ----------------------------------------------------------------
	// Channels: index 0 is channel 5, 1 is channel 6, 2 is channel 7
	// ----------------------------------------------------------------
	for (genvar i = 0; i < `NUM_BLINK_CHANNELS; i++) begin : g_chan
		// Each channel takes its enable bit and its own off-time field.
		assign channel_enable[i] = sink_enable[`CH5_SINK_ENABLE_BIT + i];
		assign channel_cfg[i].on_units = shared_on_time_units;
		assign channel_cfg[i].off_units = off_units_of(
			sink_blink_timing_a[`CH5_OFF_TIME_LSB + `OFF_TIME_FIELD_W * i +: `OFF_TIME_FIELD_W]);

		blink_channel #(
			.UNIT_CYCLES(UNIT_CYCLES),
			.CNT_W(CNT_W)
		) u_blink_channel (
			.ref_clk(ref_clk),
			.srst(srst),
			.enable(channel_enable[i]),
			.cfg(channel_cfg[i]),
			.sink_on(sink_on[i])
		);

		enable_off_a: assert property (@(posedge ref_clk) disable iff (srst)
			!sink_enable[`CH5_SINK_ENABLE_BIT + i] |=> !sink_on[i])
			else $error("sink on while its enable is clear");
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	on_decode_a: assert property (@(posedge ref_clk) disable iff (srst)
		(sink_blink_timing_a[7:6] == 2'h0 |-> channel_cfg[0].on_units == 4'h1)
		and (sink_blink_timing_a[7:6] == 2'h1 |-> channel_cfg[1].on_units == 4'h3)
		and (sink_blink_timing_a[7:6] == 2'h2 |-> channel_cfg[2].on_units == 4'h4)
		and (sink_blink_timing_a[7:6] == 2'h3 |-> channel_cfg[0].on_units == 4'h6))
		else $error("shared on time decoded wrongly");

	ch7_off_decode_a: assert property (@(posedge ref_clk) disable iff (srst)
		(sink_blink_timing_a[5:4] == 2'h0 |-> channel_cfg[2].off_units == 4'h0)
		and (sink_blink_timing_a[5:4] == 2'h3 |-> channel_cfg[2].off_units == 4'h9))
		else $error("channel 7 off time decoded wrongly");

	ch6_off_decode_a: assert property (@(posedge ref_clk) disable iff (srst)
		(sink_blink_timing_a[3:2] == 2'h2 |-> channel_cfg[1].off_units == 4'h6)
		and (sink_blink_timing_a[3:2] == 2'h1 |-> channel_cfg[1].off_units == 4'h3))
		else $error("channel 6 off time decoded wrongly");

	ch5_off_decode_a: assert property (@(posedge ref_clk) disable iff (srst)
		(sink_blink_timing_a[1:0] == 2'h3 |-> channel_cfg[0].off_units == 4'h9)
		and (sink_blink_timing_a[1:0] == 2'h0 |-> channel_cfg[0].off_units == 4'h0))
		else $error("channel 5 off time decoded wrongly");

	timing_readback_a: assert property (@(posedge ref_clk) disable iff (srst)
		(reg_wr && reg_addr == `REG_BLINK_TIMING_ADDR ##1 reg_rd && !reg_wr && reg_addr == `REG_BLINK_TIMING_ADDR)
		|=> (reg_rvalid && reg_rdata == $past(reg_wdata, 2)))
		else $error("timing register readback mismatch");

endmodule : led_sink_blink_timer
`default_nettype wire

// ==== tb/led_sink_model.sv ====
// Behavioural model of the three LED sinks that measures each lit and dark stretch.
`timescale 1ns/1ns
`default_nettype none

module led_sink_model (
	input wire logic ref_clk,
	input wire logic [2:0] sink_on,
	output logic [2:0][15:0] on_len,
	output logic [2:0][15:0] off_len
);
	logic [2:0] prev = 3'h0;
	logic [2:0][15:0] run = '0;

	// A stretch is only recorded once it ends, so a lit LED held forever never updates on_len.
	always_ff @(posedge ref_clk) begin
		for (int i = 0; i < 3; i++) begin
			prev[i] <= sink_on[i];
			if (sink_on[i] != prev[i]) begin
				if (prev[i]) begin
					on_len[i] <= run[i];
				end else begin
					off_len[i] <= run[i];
				end
				run[i] <= 16'h0001;
			end else begin
				run[i] <= run[i] + 16'h0001;
			end
		end
	end
endmodule : led_sink_model

`default_nettype wire

// ==== tb/led_sink_blink_timer_bench.sv ====
// Self-checking bench for the sink blink timer, driving its register port.
`timescale 1ns/1ns
`default_nettype none

module led_sink_blink_timer_bench;
	// Short blink unit keeps every phase a few cycles long.
	localparam int U = 4;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic reg_rvalid;
	logic [2:0] sink_on;
	logic [2:0][15:0] on_len;
	logic [2:0][15:0] off_len;
	logic [7:0] cfg;
	int failures = 0;
	int checks_done = 0;
	int cycles = 0;

	// Clock of 40 ns period.
	always #20 ref_clk = ~ref_clk;

	led_sink_blink_timer #(.UNIT_CYCLES(U), .CNT_W(32)) i_dut (.ref_clk(ref_clk), .srst(srst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sink_on(sink_on));

	led_sink_model i_leds (.ref_clk(ref_clk), .sink_on(sink_on), .on_len(on_len), .off_len(off_len));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task give_verdict;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : give_verdict

	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// The answer stands for one cycle only, so it is sampled just after the taking edge.
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		check(16'(reg_rvalid), 16'h0001);
		check(16'(reg_rdata), 16'(exp));
	endtask : rd

	// Write, then read back on the very next cycle, so the readback follows the write edge with no idle gap.
	task wr_rd(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		check(16'(reg_rvalid), 16'h0001);
		check(16'(reg_rdata), 16'(d));
	endtask : wr_rd

	function automatic logic [15:0] on_cyc(input logic [1:0] c);
		logic [15:0] u;
		case (c)
			2'h0: u = 16'h0001;
			2'h1: u = 16'h0003;
			2'h2: u = 16'h0004;
			default: u = 16'h0006;
		endcase
		return u * 16'(U);
	endfunction : on_cyc

	// Hang guard, well above the roughly 770 cycles the sequence needs.
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			give_verdict();
		end
	end

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge ref_clk);
		srst <= 1'b0;
		rd(8'h10, 8'h00);
		rd(8'h11, 8'h00);
		wr(8'h10, 8'hFF);
		rd(8'h10, 8'h7F);
		wr(8'h12, 8'hA5);
		rd(8'h12, 8'h00);
		wr(8'h11, 8'h00);
		wr(8'h10, 8'h70);
		cyc(50);
		check(16'(sink_on), 16'h0007);
		wr(8'h10, 8'h50);
		cyc(2);
		check(16'(sink_on), 16'h0005);
		// Each on code once, and every non-zero off code on every channel across the loop.
		for (int i = 0; i < 4; i++) begin
			cfg = {2'(i), 2'(1 + (i + 2) % 3), 2'(1 + (i + 1) % 3), 2'(1 + i % 3)};
			wr(8'h10, 8'h00);
			wr_rd(8'h11, cfg);
			wr(8'h10, 8'h70);
			cyc(160);
			for (int ch = 0; ch < 3; ch++) begin
				check(on_len[ch], on_cyc(cfg[7:6]));
				check(off_len[ch], 16'(cfg[2 * ch +: 2]) * 16'h0003 * 16'(U));
			end
		end
		// Drop the enable in mid off phase; the restart must begin lit.
		wr(8'h10, 8'h00);
		wr(8'h11, 8'h01);
		wr(8'h10, 8'h10);
		cyc(U + 4);
		check(16'(sink_on), 16'h0000);
		wr(8'h10, 8'h00);
		wr(8'h10, 8'h10);
		cyc(2);
		check(16'(sink_on), 16'h0001);
		give_verdict();
	end
endmodule : led_sink_blink_timer_bench

`default_nettype wire
